// *** src/pio_input_tristate.sv ***
// Purpose: per-pin input capture and tristate register logic
// Assumes: capture_clock is the modified read strobe or edge clock,
//    picked by the read control logic outside
// Notes: bypass outputs are deliberately combinational
//
// Contract
// - pad input offered raw as signal, clock
// - input delay fixed or by four-bit code
// - single rate captured by two sync flops then one system-clock register
// - double rate sampled on rising, falling edges
// - double rate streams resynchronised to system clock
// - gearbox turns pair pin into four streams
// - gear streams cross edge then system domain
// - polarity input picks sync register edge
// - latch input moves sync data onward
// - core output enable registered before pad
// - one single-rate and one double-rate register
// - non-gearing modes use single enable flop
// - gearing mode adds fast-clocked enable register
`timescale 1ns/1ps
module pio_input_tristate
   import pio_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic capture_clock,
   input wire logic pad_input,
   input wire logic [1:0] input_mode,
   input wire logic [1:0] delay_mode,
   input wire logic [DELAY_CODE_WIDTH-1:0] dynamic_delay_code,
   input wire logic sync_clock_polarity,
   input wire logic sync_transfer_latch,
   input wire logic output_enable_in,
   input wire logic gearing_double_rate_mode,
   input wire logic fast_output_clock_0,
   input wire logic fast_output_clock_1,
   input wire logic stream_ready,
   output logic comb_input_bypass,
   output logic input_clock_bypass,
   output logic strobe_delay_feed,
   output logic sdr_data,
   output logic gear_stream_pos_a,
   output logic gear_stream_neg_a,
   output logic gear_stream_pos_b,
   output logic gear_stream_neg_b,
   output logic stream_valid,
   output logic pad_output_enable
);

   ////////////////////////////////////////////////////////////////////////
   // raw pad paths

   assign comb_input_bypass = pad_input;
   assign input_clock_bypass = pad_input;
   assign strobe_delay_feed = pad_input;

   ////////////////////////////////////////////////////////////////////////
   // system clock side: single rate capture with optional delay

   logic pad_sync;
   logic [DELAY_LINE_LEN-1:0] delay_line_reg;
   logic delayed_pad;
   logic sdr_data_reg;
   input_mode_t mode_sys;

   assign mode_sys = input_mode_t'(input_mode);

   sync2 #(.WIDTH(1)) u_pad_sync
   (
      .clk(clk),
      .d(pad_input),
      .q(pad_sync)
   );

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         delay_line_reg <= '0;
      end
      else
      begin
         delay_line_reg <= {delay_line_reg[DELAY_LINE_LEN-2:0], pad_sync};
      end
   end

   always_comb
   begin
      unique case (delay_mode_t'(delay_mode))
         DELAY_NONE:
         begin
            delayed_pad = pad_sync;
         end
         DELAY_FIXED:
         begin
            delayed_pad = delay_line_reg[FIXED_DELAY_TAP];
         end
         DELAY_DYNAMIC:
         begin
            delayed_pad = delay_line_reg[dynamic_delay_code];
         end
         default:
         begin
            delayed_pad = pad_sync;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sdr_data_reg <= 1'b0;
      end
      else if (mode_sys == MODE_SDR)
      begin
         sdr_data_reg <= delayed_pad;
      end
   end

   assign sdr_data = sdr_data_reg;

   ////////////////////////////////////////////////////////////////////////
   // capture clock side: reset and mode crossings

   logic link_nrst;
   logic [1:0] mode_link_raw;
   logic [1:0] mode_seen_reg;
   input_mode_t mode_link_reg;
   input_mode_t mode_link;

   sync2 #(.WIDTH(1)) u_link_rst
   (
      .clk(capture_clock),
      .d(nrst),
      .q(link_nrst)
   );

   sync2 #(.WIDTH(2)) u_link_mode
   (
      .clk(capture_clock),
      .d(input_mode),
      .q(mode_link_raw)
   );

   // a mode code is taken only when two link samples agree, so a
   // two-bit change cannot slip through as a stray code
   always_ff @(posedge capture_clock)
   begin
      mode_seen_reg <= mode_link_raw;
   end

   always_ff @(posedge capture_clock)
   begin
      if (!link_nrst)
      begin
         mode_link_reg <= MODE_SDR;
      end
      else if (mode_seen_reg == mode_link_raw)
      begin
         mode_link_reg <= input_mode_t'(mode_link_raw);
      end
   end

   assign mode_link = mode_link_reg;

   ////////////////////////////////////////////////////////////////////////
   // double rate capture on both strobe edges

   logic pos_cap_reg;
   logic neg_cap_reg;
   logic [1:0] sync_rise_reg;
   logic [1:0] sync_fall_reg;
   logic [1:0] sync_pair;

   always_ff @(posedge capture_clock)
   begin
      pos_cap_reg <= pad_input;
      sync_rise_reg <= {neg_cap_reg, pos_cap_reg};
   end

   always_ff @(negedge capture_clock)
   begin
      neg_cap_reg <= pad_input;
      sync_fall_reg <= {pad_input, pos_cap_reg};
   end

   // falling-edge copy reaches transfer stage half a cycle sooner, leaving half a cycle less margin
   assign sync_pair = sync_clock_polarity ? sync_fall_reg
                                          : sync_rise_reg;

   ////////////////////////////////////////////////////////////////////////
   // transfer and gearbox registers

   logic [1:0] first_pair_reg;
   logic [STREAM_WIDTH-1:0] wr_word_reg;
   logic wr_valid_reg;
   logic wr_ready;

   always_ff @(posedge capture_clock)
   begin
      if (!link_nrst)
      begin
         first_pair_reg <= 2'b00;
      end
      else
      begin
         first_pair_reg <= sync_pair;
      end
   end

   always_ff @(posedge capture_clock)
   begin
      if (!link_nrst)
      begin
         wr_word_reg <= STREAM_RESET;
         wr_valid_reg <= 1'b0;
      end
      else if (wr_valid_reg && !wr_ready)
      begin
         // fifo full: hold the pending word, newer data is not taken
         wr_word_reg <= wr_word_reg;
         wr_valid_reg <= 1'b1;
      end
      else if (sync_transfer_latch && mode_link == MODE_DDR)
      begin
         wr_word_reg <= {2'b00, sync_pair};
         wr_valid_reg <= 1'b1;
      end
      else if (sync_transfer_latch && mode_link == MODE_GEAR)
      begin
         // second pair becomes stream b, first stream a
         wr_word_reg <= {sync_pair, first_pair_reg};
         wr_valid_reg <= 1'b1;
      end
      else
      begin
         wr_valid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crossing into the system clock

   logic rd_valid;
   logic rd_take;
   logic [STREAM_WIDTH-1:0] rd_data;
   logic [STREAM_WIDTH-1:0] stream_reg;
   logic stream_valid_reg;

   assign rd_take = rd_valid && (!stream_valid_reg || stream_ready);

   gear_fifo #(.WIDTH(STREAM_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .wr_clk(capture_clock),
      .wr_nrst(link_nrst),
      .wr_valid(wr_valid_reg),
      .wr_data(wr_word_reg),
      .wr_ready(wr_ready),
      .rd_clk(clk),
      .rd_nrst(nrst),
      .rd_valid(rd_valid),
      .rd_data(rd_data),
      .rd_ready(rd_take)
   );

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         stream_reg <= STREAM_RESET;
         stream_valid_reg <= 1'b0;
      end
      else if (rd_take)
      begin
         stream_reg <= rd_data;
         stream_valid_reg <= 1'b1;
      end
      else if (stream_ready)
      begin
         stream_valid_reg <= 1'b0;
      end
   end

   assign gear_stream_pos_a = stream_reg[POS_A_BIT];
   assign gear_stream_neg_a = stream_reg[NEG_A_BIT];
   assign gear_stream_pos_b = stream_reg[POS_B_BIT];
   assign gear_stream_neg_b = stream_reg[NEG_B_BIT];
   assign stream_valid = stream_valid_reg;

   ////////////////////////////////////////////////////////////////////////
   // tristate register block

   logic [FAST_CLOCKS-1:0] fast_sync;
   logic [FAST_CLOCKS-1:0] fast_prev_reg;
   logic fast_edge;
   logic oe_stage_reg;
   logic pad_oe_reg;

   sync2 #(.WIDTH(FAST_CLOCKS)) u_fast_sync
   (
      .clk(clk),
      .d({fast_output_clock_1, fast_output_clock_0}),
      .q(fast_sync)
   );

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         fast_prev_reg <= '0;
      end
      else
      begin
         fast_prev_reg <= fast_sync;
      end
   end

   assign fast_edge = |(fast_sync & ~fast_prev_reg);

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         oe_stage_reg <= OE_RESET;
      end
      else
      begin
         oe_stage_reg <= output_enable_in;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pad_oe_reg <= OE_RESET;
      end
      else if (!gearing_double_rate_mode)
      begin
         pad_oe_reg <= output_enable_in;
      end
      else if (fast_edge)
      begin
         pad_oe_reg <= oe_stage_reg;
      end
   end

   assign pad_output_enable = pad_oe_reg;

endmodule

// *** src/pio_pkg.sv ***
// Purpose: shared constants for the pad input and tristate register block
// Assumes: config inputs are static while traffic runs
// Notes: mode codes are binary, widths fixed
package pio_pkg;

   typedef enum logic [1:0]
   {
      MODE_SDR = 2'b00,
      MODE_DDR = 2'b01,
      MODE_GEAR = 2'b10,
      MODE_SPARE = 2'b11
   } input_mode_t;

   typedef enum logic [1:0]
   {
      DELAY_NONE = 2'b00,
      DELAY_FIXED = 2'b01,
      DELAY_DYNAMIC = 2'b10,
      DELAY_SPARE = 2'b11
   } delay_mode_t;

   localparam int STREAM_WIDTH = 4;
   localparam int FIFO_DEPTH = 4;
   localparam int DELAY_CODE_WIDTH = 4;
   localparam int DELAY_LINE_LEN = 16;
   localparam logic [3:0] FIXED_DELAY_TAP = 4'h7;
   localparam int FAST_CLOCKS = 2;

   // positions of the four gear streams in a stream word
   localparam int POS_A_BIT = 0;
   localparam int NEG_A_BIT = 1;
   localparam int POS_B_BIT = 2;
   localparam int NEG_B_BIT = 3;

   localparam logic [3:0] STREAM_RESET = 4'h0;
   localparam logic OE_RESET = 1'b0;

endpackage

// *** src/sync2.sv ***
// Purpose: two flip-flop synchroniser for levels and gray words
// Assumes: each bit is a level or part of a gray code
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module sync2
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk)
   begin
      meta_reg <= d;
      q <= meta_reg;
   end

endmodule

// *** src/gear_fifo.sv ***
// Purpose: dual clock fifo carrying captured words to the system clock
// Assumes: depth is a power of two
// Notes: gray pointers cross through sync2
`timescale 1ns/1ps
module gear_fifo
#(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
)
(
   input wire logic wr_clk,
   input wire logic wr_nrst,
   input wire logic wr_valid,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   input wire logic rd_clk,
   input wire logic rd_nrst,
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   input wire logic rd_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_bin_reg;
   logic [AW:0] wr_gray_reg;
   logic [AW:0] rd_bin_reg;
   logic [AW:0] rd_gray_reg;
   logic [AW:0] rd_gray_w;
   logic [AW:0] wr_gray_r;
   logic [AW:0] wr_bin_next;
   logic [AW:0] rd_bin_next;

   assign wr_bin_next = wr_bin_reg + 1'b1;
   assign rd_bin_next = rd_bin_reg + 1'b1;

   // full when write gray equals read gray with top two bits inverted
   assign wr_ready = (wr_gray_reg !=
      {~rd_gray_w[AW:AW-1], rd_gray_w[AW-2:0]});
   assign rd_valid = (rd_gray_reg != wr_gray_r);
   assign rd_data = mem_reg[rd_bin_reg[AW-1:0]];

   always_ff @(posedge wr_clk)
   begin
      if (wr_valid && wr_ready)
      begin
         mem_reg[wr_bin_reg[AW-1:0]] <= wr_data;
      end
   end

   always_ff @(posedge wr_clk)
   begin
      if (!wr_nrst)
      begin
         wr_bin_reg <= '0;
         wr_gray_reg <= '0;
      end
      else if (wr_valid && wr_ready)
      begin
         wr_bin_reg <= wr_bin_next;
         wr_gray_reg <= wr_bin_next ^ (wr_bin_next >> 1);
      end
   end

   always_ff @(posedge rd_clk)
   begin
      if (!rd_nrst)
      begin
         rd_bin_reg <= '0;
         rd_gray_reg <= '0;
      end
      else if (rd_valid && rd_ready)
      begin
         rd_bin_reg <= rd_bin_next;
         rd_gray_reg <= rd_bin_next ^ (rd_bin_next >> 1);
      end
   end

   sync2 #(.WIDTH(AW + 1)) u_rd_to_wr
   (
      .clk(wr_clk),
      .d(rd_gray_reg),
      .q(rd_gray_w)
   );

   sync2 #(.WIDTH(AW + 1)) u_wr_to_rd
   (
      .clk(rd_clk),
      .d(wr_gray_reg),
      .q(wr_gray_r)
   );

endmodule

// *** test/ddr_source_model.sv ***
// Purpose: source-synchronous data source with read control
// Assumes: link clock runs free from start
// Notes: pair k carries {neg,pos} = k mod 4
`timescale 1ns/1ps
module ddr_source_model
(
   input wire logic gear,
   input wire logic pol,
   output logic link_clock,
   output logic pad,
   output logic latch,
   output logic polarity
);
   logic [1:0] cnt;
   logic odd;
   assign polarity = pol;
   initial
   begin
      link_clock = 0;
      cnt = 0;
      pad = 0;
      latch = 0;
      odd = 0;
      #3;
      forever #80 link_clock = ~link_clock;
   end
   // neg bit between rise and fall, next pos bit after fall
   always @(posedge link_clock)
   begin
      #40;
      pad = cnt[1];
   end
   always @(negedge link_clock)
   begin
      #40;
      cnt = cnt + 2'h1;
      pad = cnt[0];
   end
   // latch every cycle, or every other one when gearing
   always @(negedge link_clock)
   begin
      odd = ~odd;
      latch = ~gear | odd;
   end
endmodule

// *** test/pio_input_tristate_sva.sv ***
// Purpose: port checks for the pad input and tristate block
// Assumes: mode and delay inputs are static during traffic
// Notes: all checks on the system clock
`timescale 1ns/1ps
module pio_input_tristate_sva
   import pio_pkg::*;
(
   input logic clk,
   input logic nrst,
   input logic pad_input,
   input logic [1:0] input_mode,
   input logic [1:0] delay_mode,
   input logic output_enable_in,
   input logic gearing_double_rate_mode,
   input logic fast_output_clock_0,
   input logic fast_output_clock_1,
   input logic stream_ready,
   input logic comb_input_bypass,
   input logic input_clock_bypass,
   input logic strobe_delay_feed,
   input logic sdr_data,
   input logic gear_stream_pos_a,
   input logic gear_stream_neg_a,
   input logic gear_stream_pos_b,
   input logic gear_stream_neg_b,
   input logic stream_valid,
   input logic pad_output_enable
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////
   sequence sdr_settled;
      (nrst && input_mode == MODE_SDR && delay_mode == DELAY_NONE)[*4];
   endsequence
   sequence fast_quiet;
      (gearing_double_rate_mode && !fast_output_clock_0
         && !fast_output_clock_1)[*5];
   endsequence
   ////////////////////////////////////////////////////////////////
   comb_bypass_a: assert property (comb_input_bypass == pad_input)
      else $error("combinational bypass differs from pad");
   clock_bypass_a: assert property (input_clock_bypass == pad_input)
      else $error("clock bypass differs from pad");
   strobe_feed_a: assert property (strobe_delay_feed == pad_input)
      else $error("strobe feed differs from pad");
   sdr_latency_a: assert property (sdr_settled |->
      sdr_data == $past(pad_input, 3))
      else $error("single rate data not three cycles behind pad");
   sdr_hold_a: assert property (input_mode != MODE_SDR |=>
      $stable(sdr_data))
      else $error("single rate data moved outside its mode");
   oe_reg_a: assert property (!gearing_double_rate_mode |=>
      pad_output_enable == $past(output_enable_in))
      else $error("enable not registered one cycle");
   gear_oe_a: assert property (fast_quiet |=>
      $stable(pad_output_enable))
      else $error("gearing enable moved without fast clock");
   word_hold_a: assert property (stream_valid && !stream_ready |=>
      stream_valid && $stable({gear_stream_neg_b, gear_stream_pos_b,
      gear_stream_neg_a, gear_stream_pos_a}))
      else $error("stream word not held while stalled");
   ddr_upper_a: assert property (stream_valid && input_mode == MODE_DDR
      |-> !gear_stream_pos_b && !gear_stream_neg_b)
      else $error("double rate word has upper bits set");
endmodule
bind pio_input_tristate pio_input_tristate_sva i_pio_input_tristate_sva(.*);

// *** test/pio_input_tristate_tb.sv ***
// Purpose: self-checking bench for the pad input and tristate block
// Assumes: source model drives the pad unless the bench takes it
// Notes: stream words are checked for pair continuity
`timescale 1ns/1ps
module pio_input_tristate_tb;
   import pio_pkg::*;
   logic clk, nrst, capture_clock, pad_input, sync_clock_polarity;
   logic [1:0] input_mode, delay_mode;
   logic [3:0] dynamic_delay_code, w, p;
   logic sync_transfer_latch, output_enable_in, gearing_double_rate_mode;
   logic fast_output_clock_0, fast_output_clock_1, stream_ready;
   logic comb_input_bypass, input_clock_bypass, strobe_delay_feed;
   logic sdr_data, gear_stream_pos_a, gear_stream_neg_a;
   logic gear_stream_pos_b, gear_stream_neg_b, stream_valid;
   logic pad_output_enable, pad_tb, use_tb, src_pad, pol, gear;
   int num_errors = 0;
   int samples_checked = 0;
   assign pad_input = use_tb ? pad_tb : src_pad;
   ddr_source_model i_ddr_source_model(.gear(gear), .pol(pol),
      .link_clock(capture_clock), .pad(src_pad),
      .latch(sync_transfer_latch), .polarity(sync_clock_polarity));
   pio_input_tristate i_pio_input_tristate(.*);
   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   task tick;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [3:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic get_word(output logic [3:0] v);
      int k;
      k = 0;
      while (stream_valid !== 1'b1 && k < 400)
      begin
         tick;
         k++;
      end
      if (k >= 400)
         chk("word_timeout", 0, 1);
      v = {gear_stream_neg_b, gear_stream_pos_b, gear_stream_neg_a,
         gear_stream_pos_a};
      tick;
   endtask
   task automatic sdr_lat(input logic [1:0] dm, input logic [3:0] c, e);
      int n;
      delay_mode = dm;
      dynamic_delay_code = c;
      repeat (20) tick;
      pad_tb = ~pad_tb;
      n = 0;
      while (sdr_data !== pad_tb && n < 30)
      begin
         tick;
         n++;
      end
      chk("sdr_latency", e, n[3:0]);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      num_errors++;
      finish_test;
   end
   initial
   begin
      nrst = 0;
      {pad_tb, use_tb, output_enable_in, gearing_double_rate_mode} = 0;
      {fast_output_clock_0, fast_output_clock_1, pol, gear} = 0;
      stream_ready = 1;
      input_mode = MODE_SDR;
      delay_mode = DELAY_NONE;
      dynamic_delay_code = 0;
      repeat (60) tick;
      nrst = 1;
      w = {1'b0, sdr_data, stream_valid, pad_output_enable};
      chk("reset", 0, w);
      use_tb = 1;
      pad_tb = 1;
      #1;
      w = {1'b0, comb_input_bypass, input_clock_bypass, strobe_delay_feed};
      chk("bypass", 7, w);
      sdr_lat(DELAY_NONE, 0, 3);
      sdr_lat(DELAY_FIXED, 0, 11);
      sdr_lat(DELAY_DYNAMIC, 5, 9);
      output_enable_in = 1;
      tick;
      chk("oe", 1, {3'b0, pad_output_enable});
      gearing_double_rate_mode = 1;
      output_enable_in = 0;
      repeat (8) tick;
      chk("oe_gear_hold", 1, {3'b0, pad_output_enable});
      fast_output_clock_0 = 1;
      repeat (2) tick;
      fast_output_clock_0 = 0;
      repeat (6) tick;
      chk("oe_gear0", 0, {3'b0, pad_output_enable});
      output_enable_in = 1;
      fast_output_clock_1 = 1;
      repeat (2) tick;
      fast_output_clock_1 = 0;
      repeat (6) tick;
      chk("oe_gear1", 1, {3'b0, pad_output_enable});
      use_tb = 0;
      input_mode = MODE_DDR;
      for (int q = 0; q < 2; q++)
      begin
         pol = q[0];
         repeat (200) tick;
         get_word(p);
         repeat (6)
         begin
            get_word(w);
            chk("ddr_word", {2'b00, p[1:0] + 2'b01}, w);
            p = w;
         end
      end
      input_mode = MODE_GEAR;
      gear = 1;
      repeat (200) tick;
      for (int q = 0; q < 2; q++)
      begin
         stream_ready = q[0];
         repeat (400) tick;
         stream_ready = 1;
         get_word(p);
         repeat (4)
         begin
            get_word(w);
            p = {w[1:0] + 2'b01, p[3:2] + 2'b01};
            chk("gear_word", p, w);
            p = w;
         end
      end
      input_mode = MODE_SPARE;
      use_tb = 1;
      pad_tb = ~pad_tb;
      repeat (200) tick;
      w = {2'b00, sdr_data, stream_valid};
      chk("spare_hold", {2'b00, ~pad_tb, 1'b0}, w);
      finish_test;
   end
endmodule
